// *** logic/imc_top.sv ***
// interpolating complex modulator: buffer, half-band chain, carrier, sinc
// assumes config ports are quasi-static and inputs synchronous to MCLK
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] ratio up to eight, or chain bypassed for a 1x path
// [R2] source keeps samples about 0.01 dB below full scale
// [R3] first stage is the 55-tap half-band, centre 32768
// [R4] second stage is the 23-tap half-band, centre 4096
// [R5] third stage is the 15-tap half-band, centre 8192
// [R6] inverse sinc is a symmetric 9-tap filter, centre 401
// [R7] complex input can be moved to positive or negative regions
// [R8] shifted modes centre the passband at odd halves of input rate
// [R9] shifted modes move only the passband, not the signal
// [R10] I on port one, Q on port two, complex carrier applied
// [R11] interleave takes I then Q from port one only
// [R12] real mode drops Q and the modulation, I is interpolated only
// [R13] software picks nonshifted mode within 0.4 of input rate
// [R14] source keeps bandwidth below 0.8 of input rate
// [R15] mode is a 4-bit field, ratio a 2-bit field
// [R16] valid mode codes depend on ratio; odd codes are shifted
// [R17] 2x uses stage one, 4x adds two, 8x adds three
// [R18] results saturate at the word limits instead of wrapping
module imc_top import imc_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire imc_interp_t CFG_INTERP,
	input wire logic [3:0] CFG_MODE,
	input wire logic CFG_INTERLEAVE,
	input wire logic CFG_REAL,
	input wire logic CFG_ISINC_EN,
	input wire logic [15:0] IN_I,
	input wire logic [15:0] IN_Q,
	input wire logic IN_VALID,
	output logic IN_READY,
	output logic [15:0] DAC_I,
	output logic [15:0] DAC_Q,
	output logic DAC_VALID
);
	// ************************************************************
	// arithmetic helpers
	// ************************************************************
	function automatic imc_smp_t sat(input logic signed [47:0] v);
		if (v > 48'sh7fff) begin
			sat = 16'sh7fff;
		end else if (v < -48'sh8000) begin
			sat = 16'sh8000;
		end else begin
			sat = v[15:0];
		end
	endfunction

	function automatic logic signed [47:0] hb(input imc_hist_t h, input int s);
		logic signed [47:0] a;
		logic signed [16:0] pr;
		int m;
		int c;
		a = '0;
		m = IMC_M[s];
		for (int j = 0; j < 14; j++) begin
			case (s)
				0: c = IMC_H1[j]; // see [R3]
				1: c = IMC_H2[j]; // see [R4]
				default: c = IMC_H3[j]; // see [R5]
			endcase
			if (j < m) begin
				pr = 17'($signed(h[j])) + 17'($signed(h[2 * m - 1 - j]));
				a = a + 48'(c * pr);
			end
		end
		hb = a;
	endfunction

	function automatic logic signed [47:0] isinc(input imc_sinc_t h);
		logic signed [47:0] a;
		logic signed [16:0] pr;
		a = 48'(IMC_IS[4] * $signed(h[4]));
		for (int j = 0; j < 4; j++) begin
			pr = 17'($signed(h[j])) + 17'($signed(h[8 - j]));
			a = a + 48'(IMC_IS[j] * pr); // see [R6]
		end
		isinc = a;
	endfunction

	function automatic imc_smp_t cosq(input logic [3:0] p);
		logic [2:0] r;
		r = {1'b0, p[1:0]};
		unique case (p[3:2])
			2'h0: cosq = IMC_COS[r];
			2'h1: cosq = -$signed(IMC_COS[3'h4 - r]);
			2'h2: cosq = -$signed(IMC_COS[r]);
			2'h3: cosq = IMC_COS[3'h4 - r];
		endcase
	endfunction

	// ************************************************************
	// state and next-state logic
	// ************************************************************
	imc_st_t st_r;
	imc_st_t st_nxt;
	logic go;
	logic pop;
	logic take;
	logic push;
	int lg;
	logic [2:0] msk;
	logic [3:0] mm;
	logic [3:0] k16;
	imc_iq_t hd;
	imc_iq_t x;
	imc_iq_t word;
	imc_smp_t cs;
	imc_smp_t sn;
	// half a unit before the shift keeps a unit carrier lossless at dc
	localparam logic signed [47:0] ROT_RND = 48'sh1 <<< (IMC_ROT_SH - 1);

	assign IN_READY = CE && st_r.cnt != 2'h2;
	assign DAC_I = st_r.dac.i;
	assign DAC_Q = st_r.dac.q;
	assign DAC_VALID = st_r.vld;

	always_comb begin
		st_nxt = st_r;
		x = '0;
		cs = '0;
		sn = '0;
		lg = int'(CFG_INTERP); // see [R15]
		msk = 3'((4'h1 << lg) - 4'h1);
		// codes above the valid range for the ratio are folded back
		mm = (lg == 0) ? 4'h0 : CFG_MODE & 4'((5'h2 << lg) - 5'h1); // see [R16]
		k16 = (lg == 0) ? 4'h0 : 4'(mm << (3 - lg)); // see [R10]
		hd = st_r.fq[st_r.rp];
		// an empty buffer at the start of an input period holds the chain
		go = CE && (st_r.c != 3'h0 || st_r.cnt != 2'h0);
		pop = go && st_r.c == 3'h0;
		take = IN_VALID && IN_READY;
		push = take && (!CFG_INTERLEAVE || st_r.half); // see [R11]
		word = CFG_INTERLEAVE ? {st_r.hold, IN_I} : {IN_I, IN_Q}; // see [R10]
		if (take && CFG_INTERLEAVE) begin
			st_nxt.half = !st_r.half;
			if (!st_r.half) begin
				st_nxt.hold = IN_I;
			end
		end
		if (push) begin
			st_nxt.fq[st_r.wp] = word;
			st_nxt.wp = !st_r.wp;
		end
		if (pop) begin
			st_nxt.rp = !st_r.rp;
		end
		st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);
		st_nxt.vld = go;
		if (go) begin
			st_nxt.c = (st_r.c + 3'h1) & msk;
			if (pop) begin
				x = hd;
				if (CFG_REAL) begin
					x.q = 16'h0000; // see [R12]
				end
				// shifted codes pre-rotate by half the input rate so the
				// passband moves while the carrier keeps the signal put
				if (mm[0] && !CFG_REAL && st_r.par) begin
					x.i = sat(-48'(x.i)); // see [R8] [R9]
					x.q = sat(-48'(x.q)); // see [R18]
				end
				st_nxt.par = !st_r.par;
				st_nxt.o[0] = x;
			end
			for (int k = 1; k < 4; k++) begin
				if (k <= lg) begin
					if ((st_r.c & (msk >> (k - 1))) == 3'h0) begin
						st_nxt.hi[k-1] = {st_r.hi[k-1][26:0], st_r.o[k-1].i};
						st_nxt.hq[k-1] = {st_r.hq[k-1][26:0], st_r.o[k-1].q};
						st_nxt.o[k].i = st_nxt.hi[k-1][IMC_M[k-1]];
						st_nxt.o[k].q = st_nxt.hq[k-1][IMC_M[k-1]];
						st_nxt.b[k-1].i = sat(hb(st_nxt.hi[k-1], k - 1)
							>>> IMC_SH[k-1]); // see [R18]
						st_nxt.b[k-1].q = sat(hb(st_nxt.hq[k-1], k - 1)
							>>> IMC_SH[k-1]);
					end else if ((st_r.c & (msk >> k)) == 3'h0) begin
						st_nxt.o[k] = st_r.b[k-1]; // see [R17]
					end
				end else begin
					st_nxt.o[k] = st_r.o[k-1]; // see [R1] [R17]
				end
			end
			st_nxt.ph = st_r.ph + k16; // see [R7] [R8]
			cs = cosq(st_r.ph);
			sn = cosq(st_r.ph - 4'h4);
			if (CFG_REAL) begin
				st_nxt.mo = {st_r.o[3].i, 16'h0000}; // see [R12]
			end else begin
				st_nxt.mo.i = sat((48'(st_r.o[3].i) * 48'(cs)
					- 48'(st_r.o[3].q) * 48'(sn) + ROT_RND)
					>>> IMC_ROT_SH); // see [R7]
				st_nxt.mo.q = sat((48'(st_r.o[3].i) * 48'(sn)
					+ 48'(st_r.o[3].q) * 48'(cs) + ROT_RND)
					>>> IMC_ROT_SH); // see [R10]
			end
			st_nxt.si = {st_r.si[7:0], st_r.mo.i};
			st_nxt.sq = {st_r.sq[7:0], st_r.mo.q};
			// the sinc gain sits below one, trading a little level for headroom
			if (CFG_ISINC_EN) begin
				st_nxt.dac.i = sat(isinc(st_nxt.si) >>> IMC_IS_SH); // see [R6]
				st_nxt.dac.q = sat(isinc(st_nxt.sq) >>> IMC_IS_SH); // see [R18]
			end else begin
				st_nxt.dac = st_r.mo;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_r <= IMC_ST_RST;
		end else if (CE) begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	logic [3:0] real_cnt;
	always_ff @(posedge MCLK) begin
		if (!RST_N || !CFG_REAL) begin
			real_cnt <= 4'h0;
		end else if (go && real_cnt != 4'hf) begin
			real_cnt <= real_cnt + 4'h1;
		end
	end

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence s_quiet7;
		(!pop || CFG_INTERP != IMC_X8) [*7];
	endsequence
	property p_rate8;
		pop && CFG_INTERP == IMC_X8 |=> s_quiet7;
	endproperty
	a_rate8: assert property (p_rate8) else $error("8x popped early"); // [R1]
	property p_x1;
		go && CFG_INTERP == IMC_X1 && $past(go)
			&& $past(CFG_INTERP) == IMC_X1 |-> pop;
	endproperty
	a_x1: assert property (p_x1) else $error("1x missed a sample"); // [R1]
	property p_bypass3;
		go && CFG_INTERP == IMC_X2 |=> st_r.o[3] == $past(st_r.o[2]);
	endproperty
	a_bypass3: assert property (p_bypass3) else $error("stage 3 not bypassed"); // [R17]
	property p_center;
		go && CFG_INTERP == IMC_X2 && st_r.c == 3'h0
			|=> st_r.o[1].i == $past(st_r.hi[0][13]);
	endproperty
	a_center: assert property (p_center) else $error("centre phase wrong"); // [R3]
	property p_phase8;
		go && CFG_INTERP == IMC_X8
			|=> st_r.ph == 4'($past(st_r.ph) + $past(CFG_MODE));
	endproperty
	a_phase8: assert property (p_phase8) else $error("carrier step wrong"); // [R8]
	property p_fdac2;
		go && CFG_INTERP == IMC_X2 && CFG_MODE == 4'h2
			|=> st_r.ph == ($past(st_r.ph) ^ 4'h8);
	endproperty
	a_fdac2: assert property (p_fdac2) else $error("fdac/2 carrier wrong"); // [R10]
	property p_real;
		real_cnt == 4'hf |-> DAC_Q == 16'h0000;
	endproperty
	a_real: assert property (p_real) else $error("q live in real mode"); // [R12]
	property p_full;
		st_r.cnt == 2'h2 |-> !IN_READY && !push ##1 st_r.cnt != 2'h0;
	endproperty
	a_full: assert property (p_full) else $error("full buffer took data"); // [R11]
	property p_il;
		push && CFG_INTERLEAVE
			|=> st_r.fq[$past(st_r.wp)].i == $past(st_r.hold);
	endproperty
	a_il: assert property (p_il) else $error("interleave pair wrong"); // [R11]
	property p_isbyp;
		go && !CFG_ISINC_EN |=> DAC_I == $past(st_r.mo.i);
	endproperty
	a_isbyp: assert property (p_isbyp) else $error("sinc bypass wrong"); // [R6]
endmodule
`default_nettype wire

// *** logic/imc_pkg.sv ***
// constants, coefficient tables and types of the interpolating modulator
// assumes one sample clock shared by the input buffer and the dac outputs
package imc_pkg;
	// ************************************************************
	// ratio codes and field positions of the configuration byte
	// ************************************************************
	typedef enum logic [1:0] {IMC_X1, IMC_X2, IMC_X4, IMC_X8} imc_interp_t;
	localparam int IMC_F_INTERP_LSB = 6;
	localparam int IMC_F_MODE_LSB = 2;
	// ************************************************************
	// half-band odd taps from the outer end, padded to one length
	// ************************************************************
	localparam int IMC_H1 [14] = '{-4, 13, -34, 72, -138, 245, -408, 650,
		-1003, 1521, -2315, 3671, -6642, 20755};
	localparam int IMC_H2 [14] = '{-2, 17, -75, 238, -660, 2530,
		0, 0, 0, 0, 0, 0, 0, 0};
	localparam int IMC_H3 [14] = '{-39, 273, -1102, 4964,
		0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
	// odd taps per side and log2 of the centre taps 32768, 4096, 8192
	localparam int IMC_M [3] = '{14, 6, 4};
	localparam int IMC_SH [3] = '{15, 12, 13};
	// inverse sinc, outer to centre; centre is 401
	localparam int IMC_IS [5] = '{2, -4, 10, -35, 401};
	localparam int IMC_IS_SH = 9;
	// ************************************************************
	// carrier: a quarter wave of cosine in sixteenths of a turn
	// ************************************************************
	localparam logic [15:0] IMC_COS [5] = '{16'h7fff, 16'h7642, 16'h5a82,
		16'h30fc, 16'h0000};
	localparam int IMC_ROT_SH = 15;
	// ************************************************************
	// sample types and state
	// ************************************************************
	typedef logic signed [15:0] imc_smp_t;
	typedef struct packed {
		imc_smp_t i;
		imc_smp_t q;
	} imc_iq_t;
	typedef logic [27:0][15:0] imc_hist_t;
	typedef logic [8:0][15:0] imc_sinc_t;
	typedef struct packed {
		imc_iq_t [1:0] fq;
		logic wp;
		logic rp;
		logic [1:0] cnt;
		imc_smp_t hold;
		logic half;
		logic par;
		logic [2:0] c;
		imc_hist_t [2:0] hi;
		imc_hist_t [2:0] hq;
		imc_iq_t [3:0] o;
		imc_iq_t [2:0] b;
		logic [3:0] ph;
		imc_iq_t mo;
		imc_sinc_t si;
		imc_sinc_t sq;
		imc_iq_t dac;
		logic vld;
	} imc_st_t;
	localparam imc_st_t IMC_ST_RST = '0;
endpackage

// *** bench/imc_src.sv ***
// source model: one word per handshake, held until it is taken
// assumes its reset is shared with the block under test
`timescale 1ns/1ps
`default_nettype none
module imc_src (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_ready,
	input wire logic en,
	input wire logic ilv,
	input wire logic rot,
	input wire logic [15:0] a,
	input wire logic [15:0] b,
	output logic in_valid,
	output logic [15:0] in_i,
	output logic [15:0] in_q
);
	logic [1:0] p;
	logic [15:0] wi, wq;
	initial {in_valid, in_i, in_q, p} = '0;
	always @(posedge clk) begin
		if (!rst_n)
			p = 2'h0;
		else if (in_valid && in_ready)
			p = p + 2'h1;
		#1;
		// rot walks a quarter-rate tone, small and narrow
		wi = rot ? (p[0] ? 16'h0 : p[1] ? -a : a) : a;
		wi = (!rot && ilv && p[0]) ? b : wi;
		wq = rot ? (p[0] ? (p[1] ? -a : a) : 16'h0) : b;
		wq = ilv ? ~b : wq;
		in_valid = en;
		// released lines flip so a stale word never looks held
		in_i = en ? wi : ~in_i;
		in_q = en ? wq : ~in_q;
	end
endmodule
`default_nettype wire

// *** bench/tb_imc_top.sv ***
// bench for the interpolating modulator, one task per scenario
// assumes the source model drives the sample ports
`timescale 1ns/1ps
`default_nettype none
module tb_imc_top import imc_pkg::*;;
	logic mclk, rst_n, ce, ilv, rl, ise, en, rot, dv, rdy, ov;
	imc_interp_t ip;
	logic [3:0] md;
	logic [15:0] a, b, di, dq;
	logic signed [15:0] oi, oq, mi, xq;
	logic signed [15:0] hi [8];
	logic signed [15:0] hq [8];
	int nout, nin, err_total, tests_run;
	imc_top u_imc_top (.MCLK(mclk), .RST_N(rst_n), .CE(ce),
		.CFG_INTERP(ip), .CFG_MODE(md), .CFG_INTERLEAVE(ilv),
		.CFG_REAL(rl), .CFG_ISINC_EN(ise), .IN_I(di), .IN_Q(dq),
		.IN_VALID(dv), .IN_READY(rdy), .DAC_I(oi), .DAC_Q(oq),
		.DAC_VALID(ov));
	imc_src u_imc_src (.clk(mclk), .rst_n(rst_n), .in_ready(rdy),
		.en(en), .ilv(ilv), .rot(rot), .a(a), .b(b),
		.in_valid(dv), .in_i(di), .in_q(dq));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// output history, newest first
	always @(posedge mclk) begin
		if (dv && rdy)
			nin++;
		if (ov === 1'b1) begin
			nout++;
			for (int k = 7; k > 0; k--) begin
				hi[k] = hi[k-1];
				hq[k] = hq[k-1];
			end
			hi[0] = oi;
			hq[0] = oq;
			if (oi < mi) mi = oi;
			if (oq > xq) xq = oq;
		end
	end
	task print_verdict;
		$display("tests %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(string nm, logic [31:0] s, logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask
	// a miss passes the raw value on, so the report shows it
	task automatic near(string nm, logic signed [15:0] s,
		logic signed [15:0] e, int t);
		logic signed [16:0] d;
		d = s - e;
		check(nm, (d <= t && d >= -t) ? e : s, e);
	endtask
	task tick;
		@(posedge mclk);
		#1;
	endtask
	task automatic setup(imc_interp_t l, logic [3:0] m,
		logic [2:0] f, logic [15:0] x, logic [15:0] y);
		rst_n = 1'b0;
		en = 1'b0;
		rot = 1'b0;
		{ilv, rl, ise} = f;
		{ip, md, a, b} = {l, m, x, y};
		repeat (3) tick;
		rst_n = 1'b1;
		en = 1'b1;
	endtask
	task automatic settle(int n);
		int t0, k;
		t0 = nout;
		k = 0;
		while (nout < t0 + n) begin
			tick;
			k++;
			if (k > 4000) begin
				check("timeout", 0, 1);
				print_verdict;
			end
		end
	endtask
	task automatic rate(int o, int n);
		int n0, o0;
		n0 = nin;
		o0 = nout;
		repeat (64) tick;
		check("outs", nout - o0, o);
		check("ins", nin - n0, n);
	endtask
	task automatic amp_ok;
		logic [31:0] pw;
		pw = hi[0] * hi[0] + hq[0] * hq[0];
		check("amp", pw > 32'h03b20b80 && pw < 32'h03ef1480, 1);
	endtask
	task test_bypass;
		setup(IMC_X1, 4'h5, 3'h0, 16'h03e8, 16'hfe0c);
		settle(20);
		check("bypass_i", oi, 32'h03e8);
		check("bypass_q", oq, 32'hfffffe0c);
		rate(64, 64);
		$display("test_bypass done");
	endtask
	task test_ratios;
		for (int k = 1; k < 4; k++) begin
			setup(imc_interp_t'(k), 4'h0, 3'h0, 16'h0bb8, 16'hf830);
			settle(400);
			near("dc_i", oi, 16'h0bb8, 8);
			near("dc_q", oq, 16'hf830, 8);
			rate(64, 64 >> k);
		end
		// source stops: the chain must drain and then stay quiet
		en = 1'b0;
		repeat (60) tick;
		rate(0, 0);
		$display("test_ratios done");
	endtask
	task test_isinc;
		setup(IMC_X1, 4'h0, 3'h1, 16'h0400, 16'h0200);
		settle(30);
		near("isinc_i", oi, 16'h02b6, 2);
		near("isinc_q", oq, 16'h015b, 2);
		$display("test_isinc done");
	endtask
	task automatic test_carrier;
		int lv [6] = '{3, 3, 3, 3, 2, 1};
		int cd [6] = '{2, 14, 4, 8, 10, 2};
		int hh [6] = '{4, 4, 2, 1, 2, 1};
		int sg [6] = '{1, -1, 1, 0, 1, 0};
		for (int k = 0; k < 6; k++) begin
			setup(imc_interp_t'(lv[k]), 4'(cd[k]), 3'h0, 16'h1f40, 16'h0);
			settle(400);
			amp_ok;
			near("half_turn", hi[0], -hi[hh[k]], 40);
			if (sg[k] != 0)
				near("dir", hq[0], 16'(sg[k] * hi[hh[k] / 2]), 40);
		end
		$display("test_carrier done");
	endtask
	task test_shift;
		for (int k = 0; k < 2; k++) begin
			// a tone at a quarter of the input rate suits both codes
			setup(IMC_X2, 4'(k), 3'h0, 16'h1f40, 16'h0);
			rot = 1'b1;
			settle(300);
			amp_ok;
			near("tone_half", hi[0], -hi[4], 40);
			near("tone_dir", hq[0], hi[2], 40);
		end
		$display("test_shift done");
	endtask
	task test_interleave;
		setup(IMC_X1, 4'h0, 3'h4, 16'h0457, 16'hf752);
		settle(20);
		check("ilv_i", oi, 32'h0457);
		check("ilv_q", oq, 32'hfffff752);
		rate(32, 64);
		$display("test_interleave done");
	endtask
	task test_real;
		setup(IMC_X2, 4'h2, 3'h2, 16'h0bb8, 16'h07d0);
		settle(100);
		check("real_q", oq, 32'h0);
		near("real_i", oi, 16'h0bb8, 8);
		$display("test_real done");
	endtask
	task test_sat;
		setup(IMC_X2, 4'h0, 3'h0, 16'h7fff, 16'h8000);
		settle(100);
		mi = 16'sh7fff;
		xq = 16'sh8000;
		settle(64);
		near("sat_i", mi, 16'sh7fff, 8);
		near("sat_q", xq, 16'sh8000, 8);
		$display("test_sat done");
	endtask
	initial begin
		{rst_n, ce, ilv, rl, ise, en, rot} = 7'h20;
		{ip, md, a, b} = '0;
		{nout, nin, err_total, tests_run} = '0;
		{mi, xq} = '0;
		tick;
		test_bypass;
		test_ratios;
		test_isinc;
		test_carrier;
		test_shift;
		test_interleave;
		test_real;
		test_sat;
		print_verdict;
	end
endmodule
`default_nettype wire
